// File: hdl/mie_pkg.sv
// Package of constants and types for the management interrupt entry block.
package mie_pkg;
    // =========================================================
    // Controller states
    typedef enum logic [3:0] {
        MIE_NORMAL = 4'h1,
        MIE_ENTRY = 4'h2,
        MIE_MODE = 4'h4,
        MIE_EXIT = 4'h8
    } mie_state_t;

    // =========================================================
    // Reset values
    localparam logic RST_IRQ_LEVEL = 1'b1;
    localparam logic RST_PENDING = 1'b0;
    localparam logic RST_ACTIVE_N = 1'b1;
    // Width of the external interrupt request vector
    localparam int EXT_IRQ_W = 8;
endpackage

// File: hdl/mie_edge_latch.sv
// Falling-edge catcher for the management interrupt pin, with synchroniser.
`timescale 1ns/100ps
`default_nettype none
module mie_edge_latch (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Pin and control
    input wire logic irq_pin_n,
    input wire logic clear,
    // Pending request
    output logic pending
);
    logic sync_a;
    logic sync_b;
    logic prev;
    logic next_pending;
    logic fall;

    always_comb begin
        fall = prev & ~sync_b;
        next_pending = pending;
        if (clear) begin
            next_pending = 1'b0;
        end
        if (fall) begin
            next_pending = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_a <= mie_pkg::RST_IRQ_LEVEL;
            sync_b <= mie_pkg::RST_IRQ_LEVEL;
            prev <= mie_pkg::RST_IRQ_LEVEL;
            pending <= mie_pkg::RST_PENDING;
        end else begin
            sync_a <= irq_pin_n;
            sync_b <= sync_a;
            prev <= sync_b;
            pending <= next_pending;
        end
    end
endmodule
`default_nettype wire

// File: hdl/mie_top.sv
// Management mode entry and exit controller.
// Contract
// - Catch every falling edge of mgmt_irq_n as one pending request.
// - Pending request enters mgmt_mode only at an instruction or string iteration boundary.
// - Pending request also taken between repeated string iterations.
// - Management request outranks every other external interrupt request.
// - No entry during locked bus cycles or while already in mgmt_mode.
// - Edge arriving during mgmt_mode is caught and kept pending.
// - Request caught in mgmt_mode served after resume_instruction, fresh entry.
// - mgmt_mode_active_n low from entry start until resume_instruction executes.
`timescale 1ns/100ps
`default_nettype none
module mie_top (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Management interrupt pin, active low
    input wire logic mgmt_irq_n,
    // Core status
    input wire logic instr_boundary,
    input wire logic string_iter_boundary,
    input wire logic bus_locked,
    input wire logic resume_instruction,
    // Other external interrupt request
    input wire logic [mie_pkg::EXT_IRQ_W-1:0] ext_irq,
    // Outputs
    output logic mgmt_entry,
    output logic ext_irq_grant,
    output logic mgmt_mode_active_n,
    output logic mgmt_pending
);
    // =========================================================
    // Edge latch
    mie_pkg::mie_state_t state;
    mie_pkg::mie_state_t next_state;
    logic pending;
    logic take;
    logic next_entry;
    logic next_grant;
    logic next_active_n;

    mie_edge_latch u_latch (
        .clk(clk),
        .arst_n(arst_n),
        .irq_pin_n(mgmt_irq_n),
        .clear(take),
        .pending(pending)
    );

    // =========================================================
    // Entry decision and mode state
    always_comb begin
        take = 1'b0;
        next_state = state;
        next_active_n = mgmt_mode_active_n;
        next_grant = 1'b0;
        case (state)
            mie_pkg::MIE_NORMAL: begin
                if (pending && !bus_locked && (instr_boundary || string_iter_boundary)) begin
                    take = 1'b1;
                    next_state = mie_pkg::MIE_ENTRY;
                    next_active_n = 1'b0;
                end else if (instr_boundary && !pending && (|ext_irq)) begin
                    next_grant = 1'b1;
                end
            end
            mie_pkg::MIE_ENTRY: begin
                next_state = mie_pkg::MIE_MODE;
            end
            mie_pkg::MIE_MODE: begin
                // Pending stays latched here; no re-entry while in mode
                if (resume_instruction) begin
                    next_state = mie_pkg::MIE_EXIT;
                    next_active_n = 1'b1;
                end
            end
            mie_pkg::MIE_EXIT: begin
                next_state = mie_pkg::MIE_NORMAL;
            end
            default: begin
                next_state = mie_pkg::MIE_NORMAL;
                next_active_n = 1'b1;
            end
        endcase
        next_entry = take;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= mie_pkg::MIE_NORMAL;
            mgmt_mode_active_n <= mie_pkg::RST_ACTIVE_N;
            mgmt_entry <= 1'b0;
            ext_irq_grant <= 1'b0;
            mgmt_pending <= mie_pkg::RST_PENDING;
        end else begin
            state <= next_state;
            mgmt_mode_active_n <= next_active_n;
            mgmt_entry <= next_entry;
            ext_irq_grant <= next_grant;
            mgmt_pending <= pending;
        end
    end
endmodule
`default_nettype wire

// File: sim/mie_top_props.sv
// Checker of the port relations of the management interrupt entry block.
`timescale 1ns/100ps
`default_nettype none
module mie_top_props (
    // Watched ports
    input wire logic clk,
    input wire logic arst_n,
    input wire logic mgmt_irq_n,
    input wire logic instr_boundary,
    input wire logic string_iter_boundary,
    input wire logic bus_locked,
    input wire logic resume_instruction,
    input wire logic mgmt_entry,
    input wire logic ext_irq_grant,
    input wire logic mgmt_mode_active_n,
    input wire logic mgmt_pending
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_entry_bound: assert property (mgmt_entry |-> $past(instr_boundary || string_iter_boundary))
        else $error("bound");
    a_entry_held: assert property (mgmt_entry |-> !$past(bus_locked) && $past(mgmt_mode_active_n))
        else $error("held");
    a_entry_act: assert property (mgmt_entry |-> !mgmt_mode_active_n) else $error("act");
    a_act_hold: assert property (!mgmt_mode_active_n && !resume_instruction |=> !mgmt_mode_active_n)
        else $error("hold");
    a_resume_exit: assert property (resume_instruction && !mgmt_mode_active_n && !mgmt_entry
        && !$past(mgmt_entry) |=> mgmt_mode_active_n) else $error("exit");
    a_fall_caught: assert property ($fell(mgmt_irq_n) |-> ##[1:5] (mgmt_pending || mgmt_entry))
        else $error("lost");
    a_grant_yield: assert property (ext_irq_grant |-> !mgmt_pending && mgmt_mode_active_n)
        else $error("prio");
    a_pend_kept: assert property (mgmt_pending && !mgmt_mode_active_n && !mgmt_entry
        && !resume_instruction |=> mgmt_pending) else $error("kept");
endmodule
bind mie_top mie_top_props u_props (.*);
`default_nettype wire

// File: sim/mie_ctrl_model.sv
// Partner model: controller that pulls the request pin low.
`timescale 1ns/100ps
`default_nettype none
module mie_ctrl_model (
    // Clock, trigger and pin
    input wire logic clk,
    input wire logic req,
    output logic irq_n
);
    initial irq_n = 1'b1;
    always @(posedge clk) begin
        if (req && irq_n) begin
            irq_n <= 1'b0;
            repeat (2) @(posedge clk);
            irq_n <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: sim/mie_top_tb.sv
// Testbench of the management interrupt entry block.
`timescale 1ns/100ps
`default_nettype none
module mie_top_tb;
    logic clk, arst_n, irq_n, ib, sb, lk, rs, req, hit, en, gr, act_n, pend;
    logic [mie_pkg::EXT_IRQ_W-1:0] ext;
    int fails, cmp_count, seed = 32'h6cbd;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    mie_ctrl_model i_ctrl (.clk(clk), .req(req), .irq_n(irq_n));
    mie_top i_dut (.clk(clk), .arst_n(arst_n), .mgmt_irq_n(irq_n), .instr_boundary(ib), .string_iter_boundary(sb),
        .bus_locked(lk), .resume_instruction(rs), .ext_irq(ext), .mgmt_entry(en), .ext_irq_grant(gr),
        .mgmt_mode_active_n(act_n), .mgmt_pending(pend));
    task chk(input string s, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("Error %s exp %b got %b", s, e, g);
        end
    endtask
    // Pulses resume (r) or a pin request for one cycle
    task pr(input bit r);
        if (r) rs <= 1'b1;
        else req <= 1'b1;
        @(posedge clk);
        if (r) rs <= 1'b0;
        else req <= 1'b0;
    endtask
    // Looks for a grant (g) or an entry pulse over 12 cycles
    task wt(input bit g, input logic e, input string s);
        hit = 1'b0;
        repeat (12) begin
            @(posedge clk);
            if ((g ? gr : en) === 1'b1) hit = 1'b1;
        end
        chk(s, e, hit);
        $display("test %s done", s);
    endtask
    task final_report;
        $display("cmp %0d fails %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        {arst_n, ib, sb, lk, rs, req} = '0;
        ext = 8'($random(seed) | 1);
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        chk("act_rst", 1'b1, act_n);
        lk <= 1'b1;
        ib <= 1'b1;
        pr(0);
        wt(0, 1'b0, "locked");
        chk("pend", 1'b1, pend);
        wt(1, 1'b0, "yield");
        lk <= 1'b0;
        wt(0, 1'b1, "entry");
        chk("act_mode", 1'b0, act_n);
        pr(0);
        wt(0, 1'b0, "in_mode");
        chk("pend_mode", 1'b1, pend);
        pr(1);
        wt(0, 1'b1, "reentry");
        ib <= 1'b0;
        sb <= 1'b1;
        pr(1);
        pr(0);
        wt(0, 1'b1, "string");
        pr(1);
        sb <= 1'b0;
        ib <= 1'b1;
        repeat (6) begin
            ext <= 8'($random(seed) | 1);
            wt(1, 1'b1, "grant");
        end
        chk("act_idle", 1'b1, act_n);
        final_report;
    end
    initial begin
        #20000;
        fails++;
        final_report;
    end
endmodule
`default_nettype wire
